// ==== core/ffp_pkg.sv ====
// package: constants for the fast interrupt, forcing and protect block
package ffp_pkg;
    localparam int          FFP_NSRC      = 32;
    localparam int          FFP_VW        = 32;
    localparam int          FFP_LW        = 3;
    localparam int          FFP_IDW       = 5;
    localparam int          FFP_DEPTH     = 8;
    localparam int          FFP_SRC0      = 0;
    localparam int          FFP_CTL_PROTECT_BIT  = 0;
    localparam int          FFP_CTL_GLOBAL_MASK_BIT  = 1;
    localparam logic [31:0] FFP_VEC_RST   = 32'h0000_0000;
    localparam logic [31:0] FFP_MASK_RST  = 32'h0000_0000;
    localparam logic [31:0] FFP_FORCE_RST = 32'h0000_0000;
    localparam logic [4:0]  FFP_SPUR_ID   = 5'h00;
endpackage

// ==== core/ffp_vec_mem.sv ====
// vector table: one word per source, registered read port
`timescale 1ns/100ps
`default_nettype none
module ffp_vec_mem #(
    parameter int DW = 32,
    parameter int AW = 5
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // write port
    input  wire logic          wr_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    // read port
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_reg [2**AW];
    logic [DW-1:0] rdata_reg;

    assign rdata_o = rdata_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_reg[i] <= '0;
            end
            rdata_reg <= '0;
        end else begin
            if (wr_i) begin
                mem_reg[waddr_i] <= wdata_i;
            end
            rdata_reg <= mem_reg[raddr_i];
        end
    end
endmodule
`default_nettype wire

// ==== core/ffp_core.sv ====
// fast interrupt path, fast forcing, protect mode, spurious and global mask
//
// Summary of operation
// [R1] fast vector read clears edge source zero
// [R2] fast vector read returns source zero vector
// [R3] core vector slot loads fast vector
// [R4] level source zero cleared by handler
// [R5] force commands set/clear force status bits
// [R6] forced source hidden from normal request
// [R7] forced source raises fast request
// [R8] forcing leaves source zero pending untouched
// [R9] fast read never clears forced sources
// [R10] normal vector read never clears forced
// [R11] source zero still feeds fast request
// [R12] protect bit selects protect mode
// [R13] protect: vector write stacks and updates
// [R14] protect: plain reads change no context
// [R15] normal read: select, return, record, push, ack
// [R16] protect read: select, return, record only
// [R17] normal mode vector writes ignored
// [R18] no pending source: spurious vector returned
// [R19] spurious handler writes end-of-interrupt
// [R20] global mask holds both requests inactive
// [R21] global mask never blocks wake-up
// [R22] debugger avoids halting between read/write
// [R23] fast line fed by source zero or forced
// [R24] enable/disable bit zero steers mask bit zero
// [R25] requests active low, high at reset
`timescale 1ns/100ps
`default_nettype none
module ffp_core
    import ffp_pkg::*;
#(
    parameter int NSRC  = ffp_pkg::FFP_NSRC,
    parameter int DEPTH = ffp_pkg::FFP_DEPTH
) (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // interrupt sources and their modes
    input  wire logic [NSRC-1:0]               src_i,
    input  wire logic [NSRC-1:0]               src_edge_i,
    input  wire logic [NSRC-1:0]               src_act_low_i,
    input  wire logic [NSRC*ffp_pkg::FFP_LW-1:0] src_prio_i,
    // command strobes, one cycle each, with bit masks
    input  wire logic                          enable_cmd_i,
    input  wire logic                          disable_cmd_i,
    input  wire logic                          clear_cmd_i,
    input  wire logic                          force_enable_cmd_i,
    input  wire logic                          force_disable_cmd_i,
    input  wire logic [NSRC-1:0]               cmd_bits_i,
    input  wire logic                          end_of_irq_cmd_i,
    // vector table and spurious vector writes
    input  wire logic                          vec_wr_i,
    input  wire logic [ffp_pkg::FFP_IDW-1:0]   vec_idx_i,
    input  wire logic [ffp_pkg::FFP_VW-1:0]    vec_data_i,
    input  wire logic                          spur_wr_i,
    // debug control
    input  wire logic                          protect_bit_i,
    input  wire logic                          global_mask_bit_i,
    // vector register accesses
    input  wire logic                          irq_vec_rd_i,
    input  wire logic                          irq_vec_wr_i,
    input  wire logic                          fast_vec_rd_i,
    // read data and status
    output logic [ffp_pkg::FFP_VW-1:0]         vec_rdata_o,
    output logic                               vec_rvalid_o,
    output logic [NSRC-1:0]                    pending_reg_o,
    output logic [NSRC-1:0]                    mask_reg_o,
    output logic [NSRC-1:0]                    force_status_reg_o,
    output logic [ffp_pkg::FFP_IDW-1:0]        current_source_reg_o,
    // processor side
    output logic                               normal_req_n_o,
    output logic                               fast_req_n_o,
    output logic                               wake_o
);
    localparam int LW  = FFP_LW;
    localparam int IDW = FFP_IDW;
    localparam int VW  = FFP_VW;
    localparam int SW  = $clog2(DEPTH + 1);
    typedef enum logic [1:0] {
        FFP_IDLE,
        FFP_LOOKUP,
        FFP_ANSWER
    } ffp_rd_type;
    ////////////////////////////////////////////////////////////////////////
    // source detection
    logic [NSRC-1:0] src_prev_reg;
    logic [NSRC-1:0] src_act;
    logic [NSRC-1:0] src_edge_hit;
    assign src_act      = src_i ^ src_act_low_i;
    assign src_edge_hit = src_act & ~(src_prev_reg ^ src_act_low_i);
    ////////////////////////////////////////////////////////////////////////
    // state
    logic [NSRC-1:0]  pend_reg, pend_next;
    logic [NSRC-1:0]  mask_reg, mask_next;
    logic [NSRC-1:0]  force_reg, force_next;
    logic [IDW-1:0]   cur_reg, cur_next;
    logic [LW-1:0]    lvl_reg, lvl_next;
    logic             busy_reg, busy_next;
    logic [SW-1:0]    sp_reg, sp_next;
    logic [LW-1:0]    stk_lvl_reg [DEPTH];
    logic [IDW-1:0]   stk_id_reg [DEPTH];
    logic [LW-1:0]    stk_lvl_next [DEPTH];
    logic [IDW-1:0]   stk_id_next [DEPTH];
    logic [IDW-1:0]   sel_reg, sel_next;
    logic [LW-1:0]    sel_lvl_reg, sel_lvl_next;
    logic             sel_spur_reg, sel_spur_next;
    logic             sel_held_reg, sel_held_next;
    ffp_rd_type       rd_reg, rd_next;
    logic             rd_fast_reg, rd_fast_next;
    logic [VW-1:0]    spur_reg, spur_next;
    logic [VW-1:0]    rdata_reg, rdata_next;
    logic             rvalid_reg, rvalid_next;
    logic             nreq_n_reg, nreq_n_next;
    logic             freq_n_reg, freq_n_next;
    logic             wake_reg, wake_next;
    logic [IDW-1:0]   mem_raddr;
    logic [VW-1:0]    mem_rdata;
    ffp_vec_mem #(
        .DW (VW),
        .AW (IDW)
    ) u_vec_mem (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .wr_i    (vec_wr_i),
        .waddr_i (vec_idx_i),
        .wdata_i (vec_data_i),
        .raddr_i (mem_raddr),
        .rdata_o (mem_rdata)
    );
    ////////////////////////////////////////////////////////////////////////
    // priority selection among enabled, pending, unforced normal sources
    logic [NSRC-1:0] cand;
    logic            best_ok;
    logic [IDW-1:0]  best_id;
    logic [LW-1:0]   best_lvl;
    logic            irq_active;
    logic            fast_active;
    always_comb begin
        cand     = pend_reg & mask_reg & ~force_reg; // [R6]
        cand[FFP_SRC0] = 1'b0;
        best_ok  = 1'b0;
        best_id  = '0;
        best_lvl = '0;
        for (int i = 1; i < NSRC; i++) begin
            if (cand[i] && (!best_ok ||
                    src_prio_i[i*LW +: LW] > best_lvl)) begin
                best_ok  = 1'b1;
                best_id  = IDW'(i);
                best_lvl = src_prio_i[i*LW +: LW];
            end
        end
        irq_active  = best_ok && (!busy_reg || best_lvl > lvl_reg);
        // [R23] [R11] source zero plus any forced source
        fast_active = (pend_reg[FFP_SRC0] && mask_reg[FFP_SRC0]) ||
                      |(pend_reg & mask_reg & force_reg); // [R7]
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        pend_next     = pend_reg;
        mask_next     = mask_reg;
        force_next    = force_reg;
        cur_next      = cur_reg;
        lvl_next      = lvl_reg;
        busy_next     = busy_reg;
        sp_next       = sp_reg;
        stk_lvl_next  = stk_lvl_reg;
        stk_id_next   = stk_id_reg;
        sel_next      = sel_reg;
        sel_lvl_next  = sel_lvl_reg;
        sel_spur_next = sel_spur_reg;
        sel_held_next = sel_held_reg;
        rd_next       = rd_reg;
        rd_fast_next  = rd_fast_reg;
        spur_next     = spur_wr_i ? vec_data_i : spur_reg;
        rdata_next    = rdata_reg;
        rvalid_next   = 1'b0;
        mem_raddr     = rd_fast_reg ? IDW'(FFP_SRC0) : sel_reg;

        // [R5] [R24] command registers
        if (enable_cmd_i)        mask_next  = mask_next | cmd_bits_i;
        if (disable_cmd_i)       mask_next  = mask_next & ~cmd_bits_i;
        if (force_enable_cmd_i)  force_next = force_next | cmd_bits_i;
        if (force_disable_cmd_i) force_next = force_next & ~cmd_bits_i;
        force_next[FFP_SRC0] = 1'b0; // [R8]
        if (clear_cmd_i) begin
            pend_next = pend_next & ~(cmd_bits_i & src_edge_i); // [R9]
        end

        // vector reads
        unique case (rd_reg)
            FFP_IDLE: begin
                if (fast_vec_rd_i) begin
                    rd_fast_next = 1'b1;
                    rd_next      = FFP_LOOKUP;
                    // [R1] only an edge source zero is auto-cleared
                    if (src_edge_i[FFP_SRC0]) begin
                        pend_next[FFP_SRC0] = 1'b0;
                    end
                end else if (irq_vec_rd_i) begin
                    rd_fast_next  = 1'b0;
                    rd_next       = FFP_LOOKUP;
                    // [R15] [R16] select and record
                    sel_next      = irq_active ? best_id : FFP_SPUR_ID;
                    sel_lvl_next  = best_lvl;
                    sel_spur_next = !irq_active; // [R18]
                    sel_held_next = protect_bit_i; // [R12]
                end
            end
            FFP_LOOKUP: begin
                rd_next = FFP_ANSWER;
            end
            FFP_ANSWER: begin
                rd_next     = FFP_IDLE;
                rvalid_next = 1'b1;
                if (rd_fast_reg) begin
                    rdata_next = mem_rdata; // [R2]
                end else if (sel_spur_reg) begin
                    rdata_next = spur_reg; // [R18]
                end else begin
                    rdata_next = mem_rdata;
                end
            end
            default: rd_next = FFP_IDLE;
        endcase

        // push and acknowledge: on read in normal mode, on write in
        // protect mode; a spurious pick stacks nothing
        if ((rd_reg == FFP_ANSWER && !rd_fast_reg && !sel_held_reg) ||
            (irq_vec_wr_i && protect_bit_i && sel_held_reg)) begin // [R13]
            sel_held_next = 1'b0; // [R17]
            if (!sel_spur_reg && sp_reg < SW'(DEPTH)) begin
                stk_lvl_next[sp_reg[SW-2:0]] = lvl_reg;
                stk_id_next[sp_reg[SW-2:0]]  = cur_reg;
                sp_next   = sp_reg + SW'(1);
                cur_next  = sel_reg; // [R14]
                lvl_next  = sel_lvl_reg;
                busy_next = 1'b1;
                if (src_edge_i[sel_reg] && !force_reg[sel_reg]) begin
                    pend_next[sel_reg] = 1'b0; // [R10]
                end
            end
        end
        if (end_of_irq_cmd_i && busy_reg) begin
            sp_next = sp_reg - SW'(1);
            if (sp_reg == SW'(1)) begin
                busy_next = 1'b0;
                lvl_next  = '0;
                cur_next  = '0;
            end else begin
                lvl_next = stk_lvl_reg[sp_reg[SW-2:0] - (SW-1)'(1)];
                cur_next = stk_id_reg[sp_reg[SW-2:0] - (SW-1)'(1)];
            end
        end

        // detection wins over any clear in the same cycle
        for (int i = 0; i < NSRC; i++) begin
            if (src_edge_i[i]) begin
                if (src_edge_hit[i]) pend_next[i] = 1'b1;
            end else begin
                pend_next[i] = src_act[i]; // [R4]
            end
        end

        // [R20] [R25] masked lines stay high
        nreq_n_next = !(irq_active && !global_mask_bit_i);
        freq_n_next = !(fast_active && !global_mask_bit_i);
        // [R21] wake-up ignores the global mask
        wake_next   = irq_active || fast_active;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_prev_reg <= '0;
            pend_reg     <= '0;
            mask_reg     <= NSRC'(FFP_MASK_RST);
            force_reg    <= NSRC'(FFP_FORCE_RST);
            cur_reg      <= '0;
            lvl_reg      <= '0;
            busy_reg     <= 1'b0;
            sp_reg       <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                stk_lvl_reg[i] <= '0;
                stk_id_reg[i]  <= '0;
            end
            sel_reg      <= '0;
            sel_lvl_reg  <= '0;
            sel_spur_reg <= 1'b0;
            sel_held_reg <= 1'b0;
            rd_reg       <= FFP_IDLE;
            rd_fast_reg  <= 1'b0;
            spur_reg     <= FFP_VEC_RST;
            rdata_reg    <= FFP_VEC_RST;
            rvalid_reg   <= 1'b0;
            nreq_n_reg   <= 1'b1;
            freq_n_reg   <= 1'b1;
            wake_reg     <= 1'b0;
        end else begin
            src_prev_reg <= src_i;
            pend_reg     <= pend_next;
            mask_reg     <= mask_next;
            force_reg    <= force_next;
            cur_reg      <= cur_next;
            lvl_reg      <= lvl_next;
            busy_reg     <= busy_next;
            sp_reg       <= sp_next;
            stk_lvl_reg  <= stk_lvl_next;
            stk_id_reg   <= stk_id_next;
            sel_reg      <= sel_next;
            sel_lvl_reg  <= sel_lvl_next;
            sel_spur_reg <= sel_spur_next;
            sel_held_reg <= sel_held_next;
            rd_reg       <= rd_next;
            rd_fast_reg  <= rd_fast_next;
            spur_reg     <= spur_next;
            rdata_reg    <= rdata_next;
            rvalid_reg   <= rvalid_next;
            nreq_n_reg   <= nreq_n_next;
            freq_n_reg   <= freq_n_next;
            wake_reg     <= wake_next;
        end
    end
    assign vec_rdata_o          = rdata_reg;
    assign vec_rvalid_o         = rvalid_reg;
    assign pending_reg_o        = pend_reg;
    assign mask_reg_o           = mask_reg;
    assign force_status_reg_o   = force_reg;
    assign current_source_reg_o = cur_reg;
    assign normal_req_n_o       = nreq_n_reg;
    assign fast_req_n_o         = freq_n_reg;
    assign wake_o               = wake_reg;
endmodule
`default_nettype wire

// ==== verification/ffp_cpu_model.sv ====
// processor core stand-in answering both request lines
`timescale 1ns/100ps
`default_nettype none
module ffp_cpu_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // bench control
    input  wire logic       en_i,
    input  wire logic [3:0] delay_i,
    input  wire logic       protect_i,
    // request lines and answer strobe
    input  wire logic       normal_req_n_i,
    input  wire logic       fast_req_n_i,
    input  wire logic       rvalid_i,
    // vector accesses
    output logic            fast_rd_o,
    output logic            irq_rd_o,
    output logic            irq_wr_o,
    output logic            eoi_o,
    output logic [7:0]      served_o
);
    int   k;
    logic took_irq;
    initial begin
        {fast_rd_o, irq_rd_o, irq_wr_o, eoi_o} = 4'h0;
        served_o = 8'h00;
        forever begin
            @(negedge clk_i);
            if (en_i && !rst_i && !(fast_req_n_i && normal_req_n_i)) begin
                // slow answers let the request age before it is taken
                repeat (delay_i) @(negedge clk_i);
                took_irq = fast_req_n_i;
                fast_rd_o = !fast_req_n_i;
                irq_rd_o = fast_req_n_i;
                @(negedge clk_i);
                fast_rd_o = 1'b0;
                irq_rd_o = 1'b0;
                for (k = 0; k < 5 && !rvalid_i; k++) @(negedge clk_i);
                if (took_irq) begin
                    irq_wr_o = protect_i;
                    @(negedge clk_i);
                    irq_wr_o = 1'b0;
                    eoi_o = 1'b1;
                    @(negedge clk_i);
                    eoi_o = 1'b0;
                end
                served_o = served_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/ffp_core_props.sv ====
// concurrent checks on the fast interrupt block ports
`timescale 1ns/100ps
`default_nettype none
module ffp_core_props
    import ffp_pkg::*;
#(
    parameter int NSRC = 32
) (
    // clock and reset
    input wire logic               clk_i,
    input wire logic               rst_i,
    // inputs
    input wire logic [NSRC-1:0]    src_edge_i,
    input wire logic [NSRC-1:0]    cmd_bits_i,
    input wire logic               force_enable_cmd_i,
    input wire logic               force_disable_cmd_i,
    input wire logic               end_of_irq_cmd_i,
    input wire logic               protect_bit_i,
    input wire logic               global_mask_bit_i,
    input wire logic               irq_vec_rd_i,
    input wire logic               irq_vec_wr_i,
    input wire logic               fast_vec_rd_i,
    // outputs
    input wire logic               vec_rvalid_o,
    input wire logic [NSRC-1:0]    pending_reg_o,
    input wire logic [NSRC-1:0]    force_status_reg_o,
    input wire logic [FFP_IDW-1:0] current_source_reg_o,
    input wire logic               normal_req_n_o,
    input wire logic               fast_req_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_any_read;
        irq_vec_rd_i || fast_vec_rd_i;
    endsequence
    sequence s_protect_bit_read;
        protect_bit_i && irq_vec_rd_i ##1
        (protect_bit_i && !irq_vec_wr_i && !end_of_irq_cmd_i)[*5];
    endsequence
    chk_reset_idle: assert property (disable iff (1'b0)
        rst_i |=> normal_req_n_o && fast_req_n_o && !vec_rvalid_o)
        else $error("requests active after reset");
    chk_mask_quiet: assert property (
        global_mask_bit_i && $past(global_mask_bit_i)
        |-> normal_req_n_o && fast_req_n_o)
        else $error("request active under global mask");
    chk_read_answer: assert property (
        s_any_read |-> ##1 !vec_rvalid_o[*2] ##1 vec_rvalid_o)
        else $error("read answer not on third cycle");
    chk_rvalid_pulse: assert property (
        vec_rvalid_o |=> !vec_rvalid_o)
        else $error("answer strobe longer than one cycle");
    chk_force_set: assert property (
        force_enable_cmd_i
        |=> ((~force_status_reg_o & $past(cmd_bits_i)) >> 1) == '0)
        else $error("force enable did not set status");
    chk_force_clear: assert property (
        force_disable_cmd_i
        |=> (force_status_reg_o & $past(cmd_bits_i)) == '0)
        else $error("force disable did not clear status");
    chk_fast_clear: assert property (
        fast_vec_rd_i && src_edge_i[0] |=> ##[0:1] !pending_reg_o[0])
        else $error("fast read left edge source zero pending");
    chk_protect_bit_quiet: assert property (
        s_protect_bit_read |-> $stable(current_source_reg_o))
        else $error("protect read changed current source");
    chk_normal_write: assert property (
        !protect_bit_i && irq_vec_wr_i |=> $stable(current_source_reg_o)[*2])
        else $error("vector write acted in normal mode");
endmodule
bind ffp_core ffp_core_props #(.NSRC(NSRC)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .src_edge_i(src_edge_i),
    .cmd_bits_i(cmd_bits_i), .force_enable_cmd_i(force_enable_cmd_i),
    .force_disable_cmd_i(force_disable_cmd_i),
    .end_of_irq_cmd_i(end_of_irq_cmd_i), .protect_bit_i(protect_bit_i),
    .global_mask_bit_i(global_mask_bit_i), .irq_vec_rd_i(irq_vec_rd_i),
    .irq_vec_wr_i(irq_vec_wr_i), .fast_vec_rd_i(fast_vec_rd_i),
    .vec_rvalid_o(vec_rvalid_o), .pending_reg_o(pending_reg_o),
    .force_status_reg_o(force_status_reg_o),
    .current_source_reg_o(current_source_reg_o),
    .normal_req_n_o(normal_req_n_o), .fast_req_n_o(fast_req_n_o)
);
`default_nettype wire

// ==== verification/ffp_core_tb.sv ====
// self-checking bench for the fast interrupt block
`timescale 1ns/100ps
`default_nettype none
module ffp_core_tb;
    import ffp_pkg::*;
    logic        clk_i, rst_i, vec_wr_i, spur_wr_i, protect_bit_i;
    logic        global_mask_bit_i, tb_irq, tb_fast, p_en, took;
    logic [31:0] src_i, src_edge_i, src_act_low_i, cmd_bits_i, vec_data_i;
    logic [31:0] vec_rdata_o, pending_reg_o, mask_reg_o, force_status_reg_o;
    logic [31:0] seed, spur, vec[0:31];
    logic [95:0] src_prio_i;
    logic [6:0]  strb;
    logic [4:0]  vec_idx_i, current_source_reg_o;
    logic        vec_rvalid_o, normal_req_n_o, fast_req_n_o, wake_o;
    logic        m_fast, m_irq, m_wr, m_eoi;
    logic [3:0]  p_dly;
    logic [7:0]  served;
    int          n_errors, n_compared, i;
    wire logic   tb_wr, tb_eoi, en_c, dis_c, clr_c, fen_c, fdis_c;
    assign {tb_wr, tb_eoi, fdis_c, fen_c, clr_c, dis_c, en_c} = strb;
    always #20 clk_i = ~clk_i;
    ffp_core DUT (.clk_i(clk_i), .rst_i(rst_i), .src_i(src_i),
        .src_edge_i(src_edge_i), .src_act_low_i(src_act_low_i),
        .src_prio_i(src_prio_i), .enable_cmd_i(en_c), .disable_cmd_i(dis_c),
        .clear_cmd_i(clr_c), .force_enable_cmd_i(fen_c),
        .force_disable_cmd_i(fdis_c), .cmd_bits_i(cmd_bits_i),
        .end_of_irq_cmd_i(tb_eoi | m_eoi), .vec_wr_i(vec_wr_i),
        .vec_idx_i(vec_idx_i), .vec_data_i(vec_data_i), .spur_wr_i(spur_wr_i),
        .protect_bit_i(protect_bit_i), .global_mask_bit_i(global_mask_bit_i),
        .irq_vec_rd_i(tb_irq | m_irq), .irq_vec_wr_i(tb_wr | m_wr),
        .fast_vec_rd_i(tb_fast | m_fast), .vec_rdata_o(vec_rdata_o),
        .vec_rvalid_o(vec_rvalid_o), .pending_reg_o(pending_reg_o),
        .mask_reg_o(mask_reg_o), .force_status_reg_o(force_status_reg_o),
        .current_source_reg_o(current_source_reg_o),
        .normal_req_n_o(normal_req_n_o), .fast_req_n_o(fast_req_n_o),
        .wake_o(wake_o));
    ffp_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .en_i(p_en),
        .delay_i(p_dly), .protect_i(protect_bit_i),
        .normal_req_n_i(normal_req_n_o), .fast_req_n_i(fast_req_n_o),
        .rvalid_i(vec_rvalid_o), .fast_rd_o(m_fast), .irq_rd_o(m_irq),
        .irq_wr_o(m_wr), .eoi_o(m_eoi), .served_o(served));
    ////////////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task end_sim();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("Error %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task tmo(input logic ok);
        if (ok !== 1'b1) begin
            $display("Error %0t: wait ran out", $time);
            n_errors++;
            end_sim();
        end
    endtask
    task cmd(input int k, input logic [31:0] bits);
        @(negedge clk_i);
        cmd_bits_i = bits;
        strb = 7'h01 << k;
        @(negedge clk_i);
        strb = 7'h00;
    endtask
    task edge_on(input int k);
        @(negedge clk_i);
        src_i[k] = 1'b1;
        @(negedge clk_i);
        src_i[k] = 1'b0;
    endtask
    task rd(input logic fast, input logic [31:0] exp);
        int k;
        @(negedge clk_i);
        tb_fast = fast;
        tb_irq = !fast;
        @(negedge clk_i);
        {tb_fast, tb_irq} = 2'b00;
        for (k = 0; k < 4 && vec_rvalid_o !== 1'b1; k++) @(negedge clk_i);
        tmo(vec_rvalid_o);
        chk(vec_rdata_o, exp);
        @(negedge clk_i);
    endtask
    task wreq(input logic fast);
        int k;
        for (k = 0; k < 8 && (fast ? fast_req_n_o : normal_req_n_o) !== 1'b0;
             k++) @(negedge clk_i);
        tmo(!(fast ? fast_req_n_o : normal_req_n_o));
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk_i) begin
        if (p_en && vec_rvalid_o === 1'b1) chk(vec_rdata_o, vec[0]);
    end
    initial begin
        {clk_i, rst_i, seed, src_i, src_edge_i} = {2'b01, 32'h160E, 64'h9};
        {src_act_low_i, src_prio_i, cmd_bits_i} = {32'h0, 96'h140, 32'h0};
        {vec_data_i, vec_idx_i, vec_wr_i, spur_wr_i, strb} = '0;
        {protect_bit_i, global_mask_bit_i, tb_irq, tb_fast, p_en} = '0;
        {p_dly, n_errors, n_compared} = '0;
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        chk({fast_req_n_o, normal_req_n_o, wake_o, vec_rvalid_o}, 32'hC);
        chk(pending_reg_o | mask_reg_o | force_status_reg_o, 32'h0);
        for (i = 0; i < 33; i++) begin
            @(negedge clk_i);
            vec_data_i = rnd();
            vec_idx_i = i[4:0];
            {vec_wr_i, spur_wr_i} = {i < 32, i == 32};
            if (i < 32) vec[i] = vec_data_i;
            else spur = vec_data_i;
        end
        @(negedge clk_i);
        {vec_wr_i, spur_wr_i} = 2'b00;
        rd(1'b1, vec[0]);
        rd(1'b0, spur);
        cmd(0, 32'hD);
        chk(mask_reg_o, 32'hD);
        edge_on(0);
        wreq(1'b1);
        rd(1'b1, vec[0]);
        chk({pending_reg_o[0], fast_req_n_o}, 32'h1);
        global_mask_bit_i = 1'b1;
        edge_on(0);
        repeat (3) @(negedge clk_i);
        chk({fast_req_n_o, wake_o}, 32'h3);
        global_mask_bit_i = 1'b0;
        wreq(1'b1);
        rd(1'b1, vec[0]);
        cmd(3, 32'h9);
        chk(force_status_reg_o, 32'h8);
        edge_on(3);
        wreq(1'b1);
        chk({normal_req_n_o, pending_reg_o[0]}, 32'h2);
        rd(1'b1, vec[0]);
        rd(1'b0, spur);
        chk(pending_reg_o[3], 32'h1);
        cmd(2, 32'h8);
        repeat (2) @(negedge clk_i);
        chk({pending_reg_o[3], fast_req_n_o}, 32'h1);
        cmd(4, 32'h8);
        chk(force_status_reg_o, 32'h0);
        protect_bit_i = 1'b1;
        src_i[2] = 1'b1;
        wreq(1'b0);
        rd(1'b0, vec[2]);
        rd(1'b0, vec[2]);
        chk(current_source_reg_o, 32'h0);
        cmd(6, 32'h0);
        @(negedge clk_i);
        chk({current_source_reg_o, normal_req_n_o}, 32'h5);
        src_i[2] = 1'b0;
        cmd(5, 32'h0);
        protect_bit_i = 1'b0;
        src_i[2] = 1'b1;
        wreq(1'b0);
        rd(1'b0, vec[2]);
        chk({current_source_reg_o, normal_req_n_o}, 32'h5);
        cmd(6, 32'h0);
        chk(current_source_reg_o, 32'h2);
        src_i[2] = 1'b0;
        cmd(5, 32'h0);
        {src_edge_i[0], src_i[0]} = 2'b01;
        wreq(1'b1);
        rd(1'b1, vec[0]);
        chk({pending_reg_o[0], fast_req_n_o}, 32'h2);
        src_i[0] = 1'b0;
        repeat (2) @(negedge clk_i);
        chk({pending_reg_o[0], fast_req_n_o}, 32'h1);
        src_edge_i[0] = 1'b1;
        p_en = 1'b1;
        for (i = 0; i < 6; i++) begin
            p_dly = i[0] ? 4'h7 : 4'h0;
            edge_on(0);
            repeat (30) if (served != 8'(i + 1)) @(negedge clk_i);
            chk({24'h0, served}, 32'(i + 1));
        end
        p_en = 1'b0;
        end_sim();
    end
endmodule
`default_nettype wire
